// >>> common/opr_pkg.sv
// Constants for the rate converter output control and page register bank.
// Assumes a byte-wide register access port decoded by the serial host interface.
package opr_pkg;
   localparam logic [6:0]  ADDR_CONV_CTL   = 7'h2d;
   localparam logic [6:0]  ADDR_OUT_LEN    = 7'h2f;
   localparam logic [6:0]  ADDR_ATTEN_L    = 7'h30;
   localparam logic [6:0]  ADDR_ATTEN_R    = 7'h31;
   localparam logic [6:0]  ADDR_RATIO_HI   = 7'h32;
   localparam logic [6:0]  ADDR_RATIO_LO   = 7'h33;
   localparam logic [6:0]  ADDR_PAGE_SEL   = 7'h7f;
   localparam logic [6:0]  CS_LAST_ADDR    = 7'h2f;
   localparam int          CS_BYTES        = 48;
   localparam logic [5:0]  CS_CRC_ADDR     = 6'h2e;
   localparam int          CS_CRC_BYTE     = 23;
   localparam int          TRACK_BIT       = 6;
   localparam int          OUT_LEN_LSB     = 6;
   localparam int          PRO_BIT         = 7;
   localparam logic [1:0]  PAGE_CTL        = 2'h0;
   localparam logic [1:0]  PAGE_RX         = 2'h1;
   localparam logic [1:0]  PAGE_TX         = 2'h2;
   localparam logic [1:0]  PAGE_RST        = 2'h0;
   localparam logic [1:0]  OUT_LEN_RST     = 2'h0;
   localparam logic [7:0]  ATTEN_RST       = 8'h00;
   localparam logic        TRACK_RST       = 1'b0;
   localparam logic [7:0]  CRC_INIT        = 8'hff;
   localparam logic [7:0]  CRC_POLY        = 8'h1d;
   // Gain is Q1.23; one step is 10^(-0.5/20) of unity.
   localparam logic [23:0] GAIN_UNITY      = 24'h800000;
   localparam logic [23:0] GAIN_STEP       = 24'h78d6fd;
   localparam logic [31:0] LFSR_SEED       = 32'h0000_0001;
   localparam logic [31:0] LFSR_TAPS       = 32'h8020_0003;
   typedef logic [7:0] opr_cs_buf_t [CS_BYTES];
endpackage

// >>> hdl/opr_regs.sv
// Output word length, attenuation, ratio readback, page select and
// channel-status buffers of the rate converter register bank.
// Assumes a byte-wide access port from the serial host decoder, one access
// per strobe, and converter samples arriving as a one-cycle valid strobe.
//
// Contract
// - Output length field picks 24/20/18/16 bits.
// - Shortening uses triangular dither before truncation.
// - Left attenuation is code times 0.5 dB.
// - Follow off: right uses its own code.
// - Follow on: right uses left code.
// - Ratio reads as integer then fraction bytes.
// - Page select decoded at 0x7F on every page.
// - Page 0 control, 1 receiver, 2 transmitter.
// - Receiver status bytes interleaved at 0x00-0x2F.
// - Byte 0 bit 7 selects professional format.
// - Transmitter inserts CRC in byte 23 itself; code does so only when byte 0 bit 7 selects professional format.
// - Follow bit is 0x2D bit 6, reset 0.
`timescale 1ns/100ps
module opr_regs #(
   parameter int SAMPLE_W = 24
) (
   input  wire logic                I_SYS_CLK,       // 125 MHz clock
   input  wire logic                I_ARST_N,        // Async reset, low
   input  wire logic [6:0]          I_REG_ADDR,      // Register address
   input  wire logic                I_REG_WR,        // Write strobe
   input  wire logic                I_REG_RD,        // Read strobe
   input  wire logic [7:0]          I_REG_WDATA,     // Write data
   output logic      [7:0]          O_REG_RDATA,     // Read data, next cycle
   output logic      [1:0]          O_PAGE,          // Selected page
   input  wire logic [4:0]          I_RATIO_INT,     // Measured ratio integer
   input  wire logic [10:0]         I_RATIO_FRAC,    // Measured ratio fraction
   input  wire logic                I_RX_CS_WE,      // Receiver buffer write
   input  wire logic [5:0]          I_RX_CS_ADDR,    // Receiver buffer index
   input  wire logic [7:0]          I_RX_CS_DATA,    // Receiver buffer byte
   input  wire logic [5:0]          I_TX_CS_ADDR,    // Transmitter fetch index
   output logic      [7:0]          O_TX_CS_DATA,    // Transmitter fetch byte
   input  wire logic                I_SAMPLE_VALID,  // Converter sample strobe
   input  wire logic [SAMPLE_W-1:0] I_SAMPLE_L,      // Left sample in
   input  wire logic [SAMPLE_W-1:0] I_SAMPLE_R,      // Right sample in
   output logic                     O_SAMPLE_VALID,  // Output sample strobe
   output logic      [SAMPLE_W-1:0] O_SAMPLE_L,      // Left sample out
   output logic      [SAMPLE_W-1:0] O_SAMPLE_R       // Right sample out
);
   logic [1:0]  page_q, page_d;
   logic [1:0]  len_q, len_d;
   logic        track_q, track_d;
   logic [7:0]  atl_q, atl_d, atr_q, atr_d;
   logic [7:0]  frac_lo_q, frac_lo_d;
   logic [7:0]  rdata_q, rdata_d;
   logic [7:0]  txd_q, txd_d;
   opr_pkg::opr_cs_buf_t rx_mem_q, rx_mem_d, tx_mem_q, tx_mem_d;
   logic [7:0]  app_q [2];
   logic [7:0]  app_d [2];
   logic [7:0]  cnt_q [2];
   logic [7:0]  cnt_d [2];
   logic [23:0] gain_q [2];
   logic [23:0] gain_d [2];
   logic [31:0] lfsr_q, lfsr_d;
   logic        ov_q, ov_d;
   logic [SAMPLE_W-1:0] ol_q, ol_d, or_q, or_d;
   logic        pro_tx;
   logic [7:0]  crc_ch [2];

   // Number of low bits dropped for each output length code.
   function automatic logic [3:0] drop_bits(input logic [1:0] sel);
      unique case (sel)
         2'h0: drop_bits = 4'h0;
         2'h1: drop_bits = 4'h4;
         2'h2: drop_bits = 4'h6;
         2'h3: drop_bits = 4'h8;
      endcase
   endfunction

   function automatic logic [23:0] gain_step(input logic [23:0] g);
      logic [47:0] p;
      p = g * opr_pkg::GAIN_STEP;
      gain_step = p[46:23];
   endfunction

   // Scales, dithers and truncates one sample.
   function automatic logic [SAMPLE_W-1:0] shape(input logic [SAMPLE_W-1:0] s,
                                                 input logic [23:0] g,
                                                 input logic [1:0] sel,
                                                 input logic [15:0] rnd);
      logic signed [SAMPLE_W+24:0] p;
      logic signed [SAMPLE_W+1:0]  v;
      logic [3:0]                  k;
      logic [SAMPLE_W+1:0]         d;
      logic [SAMPLE_W-1:0]         mask;
      p = $signed(s) * $signed({1'b0, g});
      v = (SAMPLE_W+2)'(p >>> 23);
      k = drop_bits(sel);
      mask = ~((SAMPLE_W)'(1) << k) + (SAMPLE_W)'(1);
      d = '0;
      if (k != 4'h0) begin
         // Two uniform values of k bits sum to a triangular density,
         // shifted down by one step, which leaves a mean of minus one input LSB.
         d = (SAMPLE_W+2)'(rnd[7:0] & ~(8'hff << k))
           + (SAMPLE_W+2)'(rnd[15:8] & ~(8'hff << k))
           - ((SAMPLE_W+2)'(1) << k);
      end
      v = v + $signed(d);
      if (v > $signed((SAMPLE_W+2)'({1'b0, {(SAMPLE_W-1){1'b1}}}))) begin
         shape = {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else if (v < -$signed((SAMPLE_W+2)'(1) << (SAMPLE_W-1))) begin
         shape = {1'b1, {(SAMPLE_W-1){1'b0}}};
      end else begin
         shape = v[SAMPLE_W-1:0];
      end
      shape = shape & mask;
   endfunction

   // Serial CRC over bytes 0..22 of one channel; stored bit 7 goes first.
   function automatic logic [7:0] cs_crc(input opr_pkg::opr_cs_buf_t m,
                                         input int ch);
      logic [7:0] c;
      logic [7:0] b;
      logic       fb;
      c = opr_pkg::CRC_INIT;
      for (int i = 0; i < opr_pkg::CS_CRC_BYTE; i++) begin
         b = m[2*i+ch];
         for (int j = 7; j >= 0; j--) begin
            fb = c[7] ^ b[j];
            c = {c[6:0], 1'b0} ^ (fb ? opr_pkg::CRC_POLY : 8'h00);
         end
      end
      cs_crc = c;
   endfunction

   assign pro_tx    = tx_mem_q[0][opr_pkg::PRO_BIT];
   assign crc_ch[0] = cs_crc(tx_mem_q, 0);
   assign crc_ch[1] = cs_crc(tx_mem_q, 1);

   // Host register access.
   always_comb begin
      logic p0;
      p0        = (page_q == opr_pkg::PAGE_CTL);
      page_d    = page_q;
      len_d     = len_q;
      track_d   = track_q;
      atl_d     = atl_q;
      atr_d     = atr_q;
      frac_lo_d = frac_lo_q;
      rdata_d   = rdata_q;
      rx_mem_d  = rx_mem_q;
      tx_mem_d  = tx_mem_q;
      if (I_RX_CS_WE && I_RX_CS_ADDR <= opr_pkg::CS_LAST_ADDR[5:0]) begin
         rx_mem_d[I_RX_CS_ADDR] = I_RX_CS_DATA;
      end
      if (I_REG_WR) begin
         if (I_REG_ADDR == opr_pkg::ADDR_PAGE_SEL) begin
            page_d = I_REG_WDATA[1:0];
         end else if (p0) begin
            unique case (I_REG_ADDR)
               opr_pkg::ADDR_CONV_CTL: track_d = I_REG_WDATA[opr_pkg::TRACK_BIT];
               opr_pkg::ADDR_OUT_LEN:  len_d = I_REG_WDATA[opr_pkg::OUT_LEN_LSB+:2];
               opr_pkg::ADDR_ATTEN_L:  atl_d = I_REG_WDATA;
               opr_pkg::ADDR_ATTEN_R:  atr_d = I_REG_WDATA;
               default: ;
            endcase
         end else if (page_q == opr_pkg::PAGE_TX && I_REG_ADDR <= opr_pkg::CS_LAST_ADDR) begin
            tx_mem_d[I_REG_ADDR[5:0]] = I_REG_WDATA;
         end
      end
      if (I_REG_RD) begin
         rdata_d = 8'h00;
         if (I_REG_ADDR == opr_pkg::ADDR_PAGE_SEL) begin
            rdata_d = {6'h00, page_q};
         end else if (p0) begin
            unique case (I_REG_ADDR)
               opr_pkg::ADDR_CONV_CTL: rdata_d = 8'(track_q) << opr_pkg::TRACK_BIT;
               opr_pkg::ADDR_OUT_LEN:  rdata_d = {len_q, 6'h00};
               opr_pkg::ADDR_ATTEN_L:  rdata_d = atl_q;
               opr_pkg::ADDR_ATTEN_R:  rdata_d = atr_q;
               opr_pkg::ADDR_RATIO_HI: begin
                  // The low byte is frozen here so that a following read
                  // of the next address belongs to the same measurement.
                  rdata_d   = {I_RATIO_INT, I_RATIO_FRAC[10:8]};
                  frac_lo_d = I_RATIO_FRAC[7:0];
               end
               opr_pkg::ADDR_RATIO_LO: rdata_d = frac_lo_q;
               default: ;
            endcase
         end else if (I_REG_ADDR <= opr_pkg::CS_LAST_ADDR) begin
            if (page_q == opr_pkg::PAGE_RX) begin
               rdata_d = rx_mem_q[I_REG_ADDR[5:0]];
            end else if (page_q == opr_pkg::PAGE_TX) begin
               rdata_d = tx_mem_q[I_REG_ADDR[5:0]];
            end
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         page_q    <= opr_pkg::PAGE_RST;
         len_q     <= opr_pkg::OUT_LEN_RST;
         track_q   <= opr_pkg::TRACK_RST;
         atl_q     <= opr_pkg::ATTEN_RST;
         atr_q     <= opr_pkg::ATTEN_RST;
         frac_lo_q <= 8'h00;
         rdata_q   <= 8'h00;
         rx_mem_q  <= '{default: 8'h00};
         tx_mem_q  <= '{default: 8'h00};
      end else begin
         page_q    <= page_d;
         len_q     <= len_d;
         track_q   <= track_d;
         atl_q     <= atl_d;
         atr_q     <= atr_d;
         frac_lo_q <= frac_lo_d;
         rdata_q   <= rdata_d;
         rx_mem_q  <= rx_mem_d;
         tx_mem_q  <= tx_mem_d;
      end
   end

   // Transmitter fetch port; in professional format byte 23 is the CRC.
   always_comb begin
      txd_d = 8'h00;
      if (I_TX_CS_ADDR <= opr_pkg::CS_LAST_ADDR[5:0]) begin
         txd_d = tx_mem_q[I_TX_CS_ADDR];
      end
      if (pro_tx && I_TX_CS_ADDR[5:1] == opr_pkg::CS_CRC_ADDR[5:1]) begin
         txd_d = crc_ch[I_TX_CS_ADDR[0]];
      end
   end

   // Gains are built by repeated 0.5 dB steps after a code change, which
   // trades up to 256 cycles of settling for no large lookup table.
   always_comb begin
      logic [7:0] tgt;
      tgt = 8'h00;
      for (int c = 0; c < 2; c++) begin
         tgt = (c == 0 || track_q) ? atl_q : atr_q;
         app_d[c]  = app_q[c];
         cnt_d[c]  = cnt_q[c];
         gain_d[c] = gain_q[c];
         if (tgt != app_q[c]) begin
            app_d[c]  = tgt;
            cnt_d[c]  = 8'h00;
            gain_d[c] = opr_pkg::GAIN_UNITY;
         end else if (cnt_q[c] != app_q[c]) begin
            cnt_d[c]  = cnt_q[c] + 8'h01;
            gain_d[c] = gain_step(gain_q[c]);
         end
      end
   end

   always_comb begin
      lfsr_d = lfsr_q;
      ov_d   = I_SAMPLE_VALID;
      ol_d   = ol_q;
      or_d   = or_q;
      if (I_SAMPLE_VALID) begin
         lfsr_d = {lfsr_q[30:0], ^(lfsr_q & opr_pkg::LFSR_TAPS)};
         ol_d = shape(I_SAMPLE_L, gain_q[0], len_q, lfsr_q[15:0]);
         or_d = shape(I_SAMPLE_R, gain_q[1], len_q, lfsr_q[31:16]);
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         app_q  <= '{default: 8'h00};
         cnt_q  <= '{default: 8'h00};
         gain_q <= '{default: opr_pkg::GAIN_UNITY};
         lfsr_q <= opr_pkg::LFSR_SEED;
         ov_q   <= 1'b0;
         ol_q   <= '0;
         or_q   <= '0;
         txd_q  <= 8'h00;
      end else begin
         app_q  <= app_d;
         cnt_q  <= cnt_d;
         gain_q <= gain_d;
         lfsr_q <= lfsr_d;
         ov_q   <= ov_d;
         ol_q   <= ol_d;
         or_q   <= or_d;
         txd_q  <= txd_d;
      end
   end

   assign O_REG_RDATA    = rdata_q;
   assign O_PAGE         = page_q;
   assign O_TX_CS_DATA   = txd_q;
   assign O_SAMPLE_VALID = ov_q;
   assign O_SAMPLE_L     = ol_q;
   assign O_SAMPLE_R     = or_q;

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_ARST_N);

   AST_LEN_WRITE: assert property (
      I_REG_WR && page_q == 2'h0 && I_REG_ADDR == opr_pkg::ADDR_OUT_LEN
      |=> len_q == $past(I_REG_WDATA[7:6]))
      else $error("output length not stored");
   AST_DITHER_TRUNC: assert property (
      I_SAMPLE_VALID && len_q == 2'h3 |=> O_SAMPLE_VALID && O_SAMPLE_L[7:0] == 8'h00
      && O_SAMPLE_R[7:0] == 8'h00)
      else $error("16-bit output has low bits set");
   AST_LEFT_SETTLE: assert property (
      $changed(atl_q) |-> ##[1:258] (cnt_q[0] == atl_q || $changed(atl_q)))
      else $error("left gain did not settle");
   AST_RIGHT_OWN: assert property (
      !track_q && $stable(atr_q) && !$changed(track_q) |=> app_q[1] == $past(atr_q))
      else $error("right code not its own");
   AST_RIGHT_FOLLOW: assert property (
      track_q ##1 track_q && $stable(atl_q) |=> app_q[1] == $past(atl_q))
      else $error("right does not follow left");
   AST_RATIO_PAIR: assert property (
      I_REG_RD && page_q == 2'h0 && I_REG_ADDR == opr_pkg::ADDR_RATIO_HI ##1 !I_REG_RD
      ##1 I_REG_RD && page_q == 2'h0 && I_REG_ADDR == opr_pkg::ADDR_RATIO_LO
      |=> O_REG_RDATA == $past(I_RATIO_FRAC[7:0], 3))
      else $error("ratio fraction not from snapshot");
   AST_PAGE_SEL: assert property (
      I_REG_WR && I_REG_ADDR == opr_pkg::ADDR_PAGE_SEL |=> O_PAGE == $past(I_REG_WDATA[1:0]))
      else $error("page select not taken");
   AST_PAGE3_ZERO: assert property (
      I_REG_RD && page_q == 2'h3 && I_REG_ADDR != opr_pkg::ADDR_PAGE_SEL |=> O_REG_RDATA == 8'h00)
      else $error("reserved page read not zero");
   AST_RX_MAP: assert property (
      I_REG_RD && page_q == 2'h1 && I_REG_ADDR < 7'h30
      |=> O_REG_RDATA == $past(rx_mem_q[I_REG_ADDR[5:0]]))
      else $error("receiver buffer map wrong");
   AST_CRC_INSERT: assert property (
      pro_tx && I_TX_CS_ADDR == opr_pkg::CS_CRC_ADDR |=> O_TX_CS_DATA == $past(crc_ch[0]))
      else $error("professional CRC not inserted");
   COV_TRACK: cover property (track_q && I_SAMPLE_VALID);
   COV_RATIO: cover property (I_REG_RD && I_REG_ADDR == opr_pkg::ADDR_RATIO_HI
      ##2 I_REG_RD && I_REG_ADDR == opr_pkg::ADDR_RATIO_LO);
   COV_PRO: cover property (pro_tx && I_TX_CS_ADDR == opr_pkg::CS_CRC_ADDR);
endmodule

// >>> verification/opr_host_model.sv
// Host processor model for the byte-wide register access port.
// Assumes the bench calls its task; all changes land at the falling clock edge.
`timescale 1ns/100ps
module opr_host_model (
   input  wire logic       i_clk,    // System clock
   input  wire logic [7:0] i_rdata,  // Read data from the bank
   output logic      [6:0] o_addr,   // Register address
   output logic            o_wr,     // Write strobe
   output logic            o_rd,     // Read strobe
   output logic      [7:0] o_wdata   // Write data
);
   initial begin
      o_addr  = 7'h00;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_wdata = 8'h00;
   end
   // One access per call, held across the taking edge; the read byte is picked up after it.
   task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(negedge i_clk);
      o_addr  = a;
      o_wdata = d;
      o_wr    = wr;
      o_rd    = ~wr;
      @(negedge i_clk);
      q       = i_rdata;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      // A released bus shows the inverse, so a stale address is never mistaken for a held one.
      o_addr  = ~a;
      o_wdata = ~d;
   endtask
endmodule

// >>> verification/opr_regs_tb.sv
// Self-checking bench for the rate converter output control and page register bank.
// Assumes the host model in its own file and the package constants.
`timescale 1ns/100ps
module opr_regs_tb;
   logic        clk, arst_n, wr, rd, rx_we, s_v, o_v;
   logic [6:0]  addr;
   logic [7:0]  wdata, rdata, rx_data, tx_data;
   logic [1:0]  page;
   logic [4:0]  r_int;
   logic [10:0] r_frac;
   logic [5:0]  rx_addr, tx_addr;
   logic [23:0] s_l, s_r, o_l, o_r;
   logic [7:0]  buf_q [48];
   int          num_errors, n_compared, seed, cl, cr, len, fol;
   opr_host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
                        .o_wdata(wdata));
   opr_regs uut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_REG_ADDR(addr), .I_REG_WR(wr),
      .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_PAGE(page),
      .I_RATIO_INT(r_int), .I_RATIO_FRAC(r_frac), .I_RX_CS_WE(rx_we), .I_RX_CS_ADDR(rx_addr),
      .I_RX_CS_DATA(rx_data), .I_TX_CS_ADDR(tx_addr), .O_TX_CS_DATA(tx_data),
      .I_SAMPLE_VALID(s_v), .I_SAMPLE_L(s_l), .I_SAMPLE_R(s_r), .O_SAMPLE_VALID(o_v),
      .O_SAMPLE_L(o_l), .O_SAMPLE_R(o_r));
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic wrr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.access(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [7:0] e, input string m);
      logic [7:0] q;
      host.access(1'b0, a, 8'h00, q);
      chk({16'h0, q}, {16'h0, e}, m);
   endtask
   // Serial over stored bit 7 down to bit 0 of channel 0 bytes 0 to 22.
   function automatic logic [7:0] crc_exp();
      logic [7:0] c;
      c = opr_pkg::CRC_INIT;
      for (int b = 0; b < 23; b++) begin
         for (int i = 7; i >= 0; i--) begin
            c = (c[7] ^ buf_q[2*b][i]) ? ({c[6:0], 1'b0} ^ opr_pkg::CRC_POLY) : {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction
   // Dither and rounding of the stepped gain allow a small spread around the exact product.
   task automatic near(input logic [23:0] got, input logic signed [23:0] s, input int code,
                       input int k, input string m);
      int d;
      d = $signed(got) - $rtoi(s * 10.0 ** (-code / 40.0));
      chk(got & ((24'h1 << k) - 24'h1), 24'h0, m);
      chk({23'h0, (d < 0 ? -d : d) > (2 << k) + 2 + code / 2}, 24'h0, m);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      results();
   end
   initial begin
      logic signed [23:0] l, r;
      int k, cre;
      seed = 32'hdd8070e8;
      {arst_n, rx_we, s_v, rx_addr, rx_data, tx_addr, s_l, s_r} = '0;
      r_int = 5'h15;
      r_frac = 11'h5a3;
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      chk({22'h0, page}, {22'h0, opr_pkg::PAGE_RST}, "page reset");
      rdchk(7'h2f, 8'h00, "length reset");
      rdchk(7'h2d, 8'h00, "follow reset");
      rdchk(7'h30, 8'h00, "left reset");
      rdchk(7'h31, 8'h00, "right reset");
      rdchk(7'h10, 8'h00, "unmapped");
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         r_int = 5'($random(seed));
         r_frac = 11'($random(seed));
         wrr(7'h32, 8'hff);
         rdchk(7'h32, {r_int, r_frac[10:8]}, "ratio high");
         k = r_frac[7:0];
         r_frac = ~r_frac;
         rdchk(7'h33, 8'(k), "ratio low");
      end
      $display("test ratio done");
      for (int i = 0; i < 8; i++) begin
         len = i % 4;
         fol = i / 4;
         cl = (i == 0) ? 0 : (i == 7) ? 255 : ($random(seed) & 8'hff);
         cr = $random(seed) & 8'hff;
         wrr(7'h2f, {2'(len), 6'($random(seed))});
         wrr(7'h30, 8'(cl));
         wrr(7'h31, 8'(cr));
         wrr(7'h2d, 8'(fol << opr_pkg::TRACK_BIT) | 8'h0f);
         rdchk(7'h2f, 8'(len << opr_pkg::OUT_LEN_LSB), "length field");
         rdchk(7'h2d, 8'(fol << opr_pkg::TRACK_BIT), "follow bit");
         repeat ((cl > cr ? cl : cr) + 2) @(posedge clk);
         k = (len == 0) ? 0 : 2 * len + 2;
         cre = fol ? cl : cr;
         repeat (2) begin
            l = 24'($signed($random(seed)) % 2097152);
            r = 24'($signed($random(seed)) % 2097152);
            @(negedge clk);
            {s_v, s_l, s_r} = {1'b1, l, r};
            @(negedge clk);
            {s_v, s_l, s_r} = {1'b0, ~l, ~r};
            chk({23'h0, o_v}, 24'h1, "sample strobe");
            near(o_l, l, cl, k, "left sample");
            near(o_r, r, cre, k, "right sample");
         end
      end
      $display("test attenuation done");
      wrr(7'h7f, 8'h01);
      chk({22'h0, page}, 24'h1, "page one");
      rdchk(7'h7f, 8'h01, "page readback");
      for (int j = 0; j < 48; j++) begin
         buf_q[j] = 8'($random(seed));
         @(negedge clk);
         {rx_we, rx_addr, rx_data} = {1'b1, 6'(j), buf_q[j]};
         @(negedge clk);
         rx_we = 1'b0;
      end
      wrr(7'h00, ~buf_q[0]);
      for (int j = 0; j < 48; j++) begin
         rdchk(7'(j), buf_q[j], "receiver buffer");
      end
      rdchk(7'h30, 8'h00, "above buffer");
      wrr(7'h7f, 8'h02);
      buf_q[0][opr_pkg::PRO_BIT] = 1'b1;
      for (int b = 0; b < 24; b++) begin
         wrr(7'(2 * b), buf_q[2*b]);
      end
      rdchk(7'h00, buf_q[0], "transmitter buffer");
      rdchk(7'h2e, buf_q[46], "stored byte 23");
      @(negedge clk);
      tx_addr = opr_pkg::CS_CRC_ADDR;
      @(negedge clk);
      chk({16'h0, tx_data}, {16'h0, crc_exp()}, "professional crc");
      buf_q[0][opr_pkg::PRO_BIT] = 1'b0;
      wrr(7'h00, buf_q[0]);
      @(negedge clk);
      chk({16'h0, tx_data}, {16'h0, buf_q[46]}, "consumer byte 23");
      wrr(7'h7f, 8'h03);
      wrr(7'h30, 8'h12);
      rdchk(7'h30, 8'h00, "reserved page");
      wrr(7'h7f, 8'h00);
      chk({22'h0, page}, 24'h0, "back to page 0");
      rdchk(7'h30, 8'hff, "left kept");
      $display("test pages done");
      // A sample on a step boundary at unity gain gives one level under plain truncation.
      wrr(7'h2f, 8'hc0);
      wrr(7'h30, 8'h00);
      cre = 0;
      repeat (16) begin
         @(negedge clk);
         {s_v, s_l} = {1'b1, 24'h000100};
         @(negedge clk);
         s_v = 1'b0;
         near(o_l, 24'sh000100, 0, 8, "dithered level");
         cre += (o_l == 24'h000100) ? 1 : 0;
      end
      chk({23'h0, cre == 0 || cre == 16}, 24'h0, "dither absent");
      $display("test dither done");
      results();
   end
endmodule
